// ===== rtl/ncdo_map.svh
`ifndef NCDO_MAP_SVH
`define NCDO_MAP_SVH
// register byte addresses
`define NCDO_ADDR_DIV 5'h00
`define NCDO_ADDR_OPT 5'h04
`define NCDO_ADDR_KCTL 5'h08
`define NCDO_ADDR_KDAT 5'h0c
`define NCDO_ADDR_STAT 5'h10
// divider register fields
`define NCDO_DIV_LOADED 7
`define NCDO_DIV_PRESCALE 6
`define NCDO_DIV_RESET 7'h00
`define NCDO_PRESCALE_LAST 3'h7
// options register fields
`define NCDO_OPT_BACKDOOR_KEY_ENABLE 7
`define NCDO_OPT_NORED 6
`define NCDO_OPT_USED_MASK 8'hc3
`define NCDO_OPT_RESET 8'h00
`define NCDO_SEC_UNSECURE 2'h2
// backdoor key
`define NCDO_KEY_BYTES 4'h8
// bus answers
`define NCDO_RESP_OK 2'h0
`define NCDO_RESP_SLVERR 2'h2
`endif

// ===== rtl/ncdo_pkg.sv
package ncdo_pkg;
  typedef logic [7:0] ncdo_byte_t;
  typedef logic [5:0] ncdo_ratio_t;
  typedef enum logic [0:0] {
    NCDO_OP_IDLE = 1'b0,
    NCDO_OP_RUN = 1'b1
  } ncdo_op_e;
endpackage

// ===== rtl/ncdo_tick.sv
`include "ncdo_map.svh"
module ncdo_tick (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic prescale,
  input wire ncdo_pkg::ncdo_ratio_t ratio,
  output logic tick
);
  import ncdo_pkg::*;

  logic [2:0] pre_q;
  logic [2:0] pre_d;
  ncdo_ratio_t div_q;
  ncdo_ratio_t div_d;
  logic tick_q;
  wire pre_en;
  wire div_end;

  // divide-by-8 prescale or plain bus clock
  assign pre_en = !prescale || (pre_q == `NCDO_PRESCALE_LAST); // R4
  assign div_end = (div_q >= ratio); // R5
  assign pre_d = (run && prescale) ? pre_q + 3'h1 : 3'h0;
  assign div_d = (!run || (pre_en && div_end)) ? 6'h00 :
                 (pre_en ? div_q + 6'h01 : div_q);
  assign tick = tick_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_q <= 3'h0;
      div_q <= 6'h00;
      tick_q <= 1'b0;
    end
    else
    begin
      pre_q <= pre_d;
      div_q <= div_d;
      tick_q <= run && pre_en && div_end; // R19
    end
  end
endmodule

// ===== rtl/ncdo_top.sv
// Local design decisions: the Avalon-MM interface to the registers and the register offsets.
`include "ncdo_map.svh"
// Overview of operation
// (R1) divider bit7 read-only, low bits written once
// (R2) reset clears loaded flag, first write sets
// (R3) program/erase refused until divider loaded
// (R4) prescale bit selects bus clock or /8
// (R5) timing clock is input over ratio plus one
// (R6) software keeps timing clock 150-200 kHz
// (R7) pulses last one tick, whole tick counts
// (R8) options captured from nonvolatile byte at reset
// (R9) option bits 5:2 read zero, writes ignored
// (R10) options change only via reprogram and reset; here an unlock also sets the security bits to 10
// (R11) key disabled means no backdoor unlock
// (R12) key writes only from firmware, not debug
// (R13) eight matching ascending bytes unlock until reset
// (R14) redirect disable bit turns redirection off
// (R15) only security code 10 means unsecured
// (R16) secure blocks unsecured memory accesses
// (R17) key unlock or erased blank check unsecures
// (R18) blocked writes ignored, blocked reads zero
// (R19) divider is tick enable, no derived clock
module ncdo_top (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic [1:0] AVS_RESPONSE,
  output logic AVS_WAITREQUEST,
  input wire logic DEBUG_ACCESS,
  input wire ncdo_pkg::ncdo_byte_t OPTION_BYTE,
  input wire logic [63:0] BACKDOOR_KEY,
  input wire logic OP_REQUEST,
  input wire ncdo_pkg::ncdo_byte_t OP_PULSES,
  output logic OP_ACCEPT,
  output logic OP_REFUSED,
  output logic OP_BUSY,
  output logic OP_DONE,
  output logic TIMING_TICK,
  input wire logic BLANK_CHECK_DONE,
  input wire logic BLANK_CHECK_ERASED,
  input wire logic MEM_READ,
  input wire logic MEM_WRITE,
  input wire logic MEM_UNSECURED_SRC,
  input wire ncdo_pkg::ncdo_byte_t MEM_RDATA,
  output logic MEM_WRITE_EN,
  output ncdo_pkg::ncdo_byte_t MEM_RDATA_OUT,
  output logic REDIRECT_ENABLE,
  output logic SECURE
);
  import ncdo_pkg::*;

  // bus slave state
  logic wait_q;
  logic [31:0] rdata_q;
  logic [1:0] resp_q;
  // divider register
  logic loaded_q;
  logic [6:0] div_q;
  // options register and key logic
  logic opt_done_q;
  ncdo_byte_t opt_q;
  ncdo_byte_t opt_d;
  logic kacc_q;
  logic [3:0] kidx_q;
  logic kbad_q;
  // sequencer
  ncdo_op_e op_q;
  ncdo_byte_t left_q;
  logic accept_q;
  logic refused_q;
  logic done_q;
  // security outputs
  logic wen_q;
  ncdo_byte_t mrd_q;
  logic redir_q;
  logic secure_q;
  logic tick;

  // bus decode
  wire req = AVS_READ || AVS_WRITE;
  wire take = req && wait_q;
  wire commit = req && !wait_q;
  wire be0 = AVS_BYTEENABLE[0];
  wire hit_div = (AVS_ADDRESS == `NCDO_ADDR_DIV);
  wire hit_opt = (AVS_ADDRESS == `NCDO_ADDR_OPT);
  wire hit_kctl = (AVS_ADDRESS == `NCDO_ADDR_KCTL);
  wire hit_kdat = (AVS_ADDRESS == `NCDO_ADDR_KDAT);
  wire hit_stat = (AVS_ADDRESS == `NCDO_ADDR_STAT);
  wire mapped = hit_div || hit_opt || hit_kctl || hit_kdat || hit_stat;
  wire wr = commit && AVS_WRITE && be0;
  wire wr_div = wr && hit_div;
  wire wr_kctl = wr && hit_kctl;
  wire wr_kdat = wr && hit_kdat;

  // security view
  wire backdoor_key_enable = opt_q[`NCDO_OPT_BACKDOOR_KEY_ENABLE];
  wire sec_now = (opt_q[1:0] != `NCDO_SEC_UNSECURE); // R15
  wire blocked = sec_now && MEM_UNSECURED_SRC; // R16

  // backdoor key compare
  wire [5:0] key_lsb = {kidx_q[2:0], 3'h0};
  wire ncdo_byte_t key_byte = BACKDOOR_KEY[key_lsb +: 8];
  wire key_wr = wr_kdat && kacc_q && backdoor_key_enable && !DEBUG_ACCESS; // R11 R12
  wire key_full = (kidx_q == `NCDO_KEY_BYTES);
  wire key_miss = key_full || (AVS_WRITEDATA[7:0] != key_byte);
  wire key_close = wr_kctl && kacc_q && !AVS_WRITEDATA[0];
  wire key_unlock = key_close && backdoor_key_enable && key_full && !kbad_q; // R13
  wire blank_unlock = BLANK_CHECK_DONE && BLANK_CHECK_ERASED;
  wire unlock = key_unlock || blank_unlock; // R17

  // read mux
  wire [31:0] rd_div = {24'h0, loaded_q, div_q};
  wire [31:0] rd_opt = {24'h0, opt_q & `NCDO_OPT_USED_MASK}; // R9
  wire [31:0] rd_kctl = {27'h0, kbad_q, kidx_q[2:0], kacc_q};
  wire [31:0] rd_stat = {28'h0, OP_BUSY, loaded_q, REDIRECT_ENABLE, SECURE};
  wire [31:0] rd_mux = hit_div ? rd_div :
                       hit_opt ? rd_opt :
                       hit_kctl ? rd_kctl :
                       hit_stat ? rd_stat : 32'h0;

  // capture of the option byte on the first edge after reset
  assign opt_d = !opt_done_q ? (OPTION_BYTE & `NCDO_OPT_USED_MASK) : // R8
                 (unlock ? {opt_q[7:2], `NCDO_SEC_UNSECURE} : opt_q); // R17

  // sequencer decode
  wire start = OP_REQUEST && loaded_q && (op_q == NCDO_OP_IDLE); // R3
  wire last = tick && (left_q <= 8'h01); // R7

  assign AVS_WAITREQUEST = wait_q;
  assign AVS_READDATA = rdata_q;
  assign AVS_RESPONSE = resp_q;
  assign OP_ACCEPT = accept_q;
  assign OP_REFUSED = refused_q;
  assign OP_BUSY = (op_q == NCDO_OP_RUN);
  assign OP_DONE = done_q;
  assign TIMING_TICK = tick;
  assign MEM_WRITE_EN = wen_q;
  assign MEM_RDATA_OUT = mrd_q;
  assign REDIRECT_ENABLE = redir_q;
  assign SECURE = secure_q;

  ncdo_tick u_tick (
    .clk(CLOCK),
    .rst_n(RESETN),
    .run(loaded_q),
    .prescale(div_q[`NCDO_DIV_PRESCALE]),
    .ratio(div_q[5:0]),
    .tick(tick)
  );

  // bus answer one cycle after the request is seen
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
      resp_q <= `NCDO_RESP_OK;
    end
    else
    begin
      wait_q <= !take;
      if (take)
      begin
        rdata_q <= AVS_READ ? rd_mux : 32'h0;
        resp_q <= mapped ? `NCDO_RESP_OK : `NCDO_RESP_SLVERR;
      end
    end
  end

  // divider register, write once
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      loaded_q <= 1'b0; // R2
      div_q <= `NCDO_DIV_RESET;
    end
    else if (wr_div && !loaded_q)
    begin
      loaded_q <= 1'b1; // R2
      div_q <= AVS_WRITEDATA[6:0]; // R1
    end
  end

  // options register, no bus write path
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      opt_done_q <= 1'b0;
      opt_q <= `NCDO_OPT_RESET;
    end
    else
    begin
      opt_done_q <= 1'b1;
      opt_q <= opt_d; // R9
    end
  end

  // key entry state
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      kacc_q <= 1'b0;
      kidx_q <= 4'h0;
      kbad_q <= 1'b0;
    end
    else if (wr_kctl)
    begin
      kacc_q <= AVS_WRITEDATA[0];
      kidx_q <= 4'h0;
      kbad_q <= 1'b0;
    end
    else if (key_wr)
    begin
      kidx_q <= key_full ? kidx_q : kidx_q + 4'h1; // R13
      kbad_q <= kbad_q || key_miss;
    end
  end

  // program and erase sequencer
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      op_q <= NCDO_OP_IDLE;
      left_q <= 8'h00;
      accept_q <= 1'b0;
      refused_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      accept_q <= start;
      refused_q <= OP_REQUEST && !start; // R3
      done_q <= (op_q == NCDO_OP_RUN) && last;
      case (op_q)
        NCDO_OP_IDLE:
        begin
          if (start)
          begin
            op_q <= NCDO_OP_RUN;
            left_q <= OP_PULSES;
          end
        end
        NCDO_OP_RUN:
        begin
          if (last)
          begin
            op_q <= NCDO_OP_IDLE; // R7
          end
          else if (tick)
          begin
            left_q <= left_q - 8'h01;
          end
        end
        default:
        begin
          op_q <= NCDO_OP_IDLE;
        end
      endcase
    end
  end

  // security gate and decoded option outputs
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      wen_q <= 1'b0;
      mrd_q <= 8'h00;
      redir_q <= 1'b0;
      secure_q <= 1'b1;
    end
    else
    begin
      wen_q <= MEM_WRITE && !blocked; // R18
      mrd_q <= (MEM_READ && !blocked) ? MEM_RDATA : 8'h00; // R18
      redir_q <= opt_done_q && !opt_q[`NCDO_OPT_NORED]; // R14
      secure_q <= !opt_done_q || sec_now; // R15
    end
  end

  // cycles since the last tick, for checking
  logic [9:0] gap_q;
  wire [9:0] period = div_q[6] ? {1'b0, div_q[5:0], 3'h7} :
                      {4'h0, div_q[5:0]};
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      gap_q <= 10'h0;
    end
    else
    begin
      // all ones before load, so the first tick counts like the rest
      gap_q <= tick ? 10'h0 : (!loaded_q ? 10'h3ff : gap_q + 10'h1);
    end
  end

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESETN);

  sequence s_refused_req;
    OP_REQUEST && !loaded_q;
  endsequence
  sequence s_blocked_read;
    MEM_READ && MEM_UNSECURED_SRC && sec_now;
  endsequence
  sequence s_loaded_write;
    wr_div && loaded_q;
  endsequence

  a_div_write_once: assert property (s_loaded_write |=> $stable(div_q)) // R1
    else $error("divider field changed after first write");
  a_first_write_sets: assert property (wr_div && !loaded_q |=> loaded_q && div_q == $past(AVS_WRITEDATA[6:0])) // R2
    else $error("first divider write not taken");
  a_refuse_unloaded: assert property (s_refused_req |=> OP_REFUSED && !OP_ACCEPT && !OP_BUSY) // R3
    else $error("operation not refused before divider load");
  a_tick_period: assert property (loaded_q && $past(loaded_q) && $stable(div_q) && tick && $past(tick, 2) == 1'b0 |-> gap_q == period) // R4 R5
    else $error("tick period wrong for divider setting");
  a_done_on_tick: assert property (OP_DONE |-> $past(tick) && $past(OP_BUSY)) // R7
    else $error("operation ended off a tick");
  a_options_readonly: assert property (wr && hit_opt && opt_done_q && !unlock |=> $stable(opt_q) ##0 opt_q[5:2] == 4'h0) // R9
    else $error("options register changed by write");
  a_key_disabled: assert property (opt_done_q && !backdoor_key_enable && !blank_unlock |=> $stable(opt_q[1:0])) // R11
    else $error("security changed with key disabled");
  a_debug_key: assert property (wr_kdat && DEBUG_ACCESS && !wr_kctl |=> $stable(kidx_q) && $stable(kbad_q)) // R12
    else $error("debug write reached key compare");
  a_key_unlocks: assert property (key_unlock |=> opt_q[1:0] == `NCDO_SEC_UNSECURE ##1 !SECURE) // R13 R17
    else $error("matching key did not unsecure");
  a_redirect_bit: assert property (opt_done_q |=> REDIRECT_ENABLE == !$past(opt_q[6])) // R14
    else $error("redirect output mismatch");
  a_secure_block: assert property (s_blocked_read |=> MEM_RDATA_OUT == 8'h00) // R16 R18
    else $error("blocked read returned data");
  a_block_write: assert property (MEM_WRITE && MEM_UNSECURED_SRC && sec_now |=> !MEM_WRITE_EN) // R18
    else $error("blocked write passed");
endmodule

// ===== tb/ncdo_nvm_model.sv
module ncdo_nvm_model (
  input wire logic clk,
  input wire logic image,
  input wire logic mem_read,
  output ncdo_pkg::ncdo_byte_t opt,
  output logic [63:0] key,
  output ncdo_pkg::ncdo_byte_t rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  import ncdo_pkg::*;
  ncdo_byte_t idle_q = 8'h00;
  // second image is the reprogrammed option byte
  assign opt = image ? 8'h3f : 8'hfd;
  assign key = 64'h0123456789abcdef;
  // array data wanders when not read
  assign rdata = mem_read ? 8'h5a : idle_q;
  always @(posedge clk)
    idle_q <= idle_q + 8'h37;
endmodule

// ===== tb/nvm_clock_divider_and_options_bench.sv
`include "ncdo_map.svh"
module nvm_clock_divider_and_options_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import ncdo_pkg::*;
  typedef struct {logic w; logic [4:0] a; logic [7:0] d; logic [31:0] e; logic [1:0] r;} ncdo_row_s;
  logic clock = 0, resetn = 0, rd = 0, wr = 0, dbg = 0, image = 0, opreq = 0;
  logic bcd = 0, bce = 0, mrd = 0, mwr = 0, munsec = 0;
  logic waitreq, acc, refd, busy, done, tick, mwen, redir, secure, a, r;
  logic [4:0] addr = 5'h00;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic [3:0] be = 4'h1;
  logic [1:0] resp, s;
  logic [63:0] key;
  ncdo_byte_t opt, mdata, mout;
  ncdo_byte_t pulses = 8'h03;
  int fails = 0, checked = 0, g, n;
  ncdo_row_s rows[11] = '{
    '{0, `NCDO_ADDR_DIV, 0, 32'h00, 0},
    '{0, `NCDO_ADDR_OPT, 0, 32'hc1, 0},
    '{1, `NCDO_ADDR_OPT, 8'hff, 0, 0},
    '{0, `NCDO_ADDR_OPT, 0, 32'hc1, 0},
    '{0, `NCDO_ADDR_STAT, 0, 32'h01, 0},
    '{1, `NCDO_ADDR_DIV, 8'h5f, 0, 0},
    '{0, `NCDO_ADDR_DIV, 0, 32'hdf, 0},
    '{1, `NCDO_ADDR_DIV, 8'h05, 0, 0},
    '{0, `NCDO_ADDR_DIV, 0, 32'hdf, 0},
    '{0, 5'h14, 0, 32'h00, 2'h2},
    '{1, 5'h18, 8'h11, 0, 2'h2}
  };
  ncdo_top ncdo_top_inst (
    .CLOCK(clock), .RESETN(resetn), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_RESPONSE(resp),
    .AVS_WAITREQUEST(waitreq), .DEBUG_ACCESS(dbg), .OPTION_BYTE(opt), .BACKDOOR_KEY(key),
    .OP_REQUEST(opreq), .OP_PULSES(pulses), .OP_ACCEPT(acc), .OP_REFUSED(refd),
    .OP_BUSY(busy), .OP_DONE(done), .TIMING_TICK(tick), .BLANK_CHECK_DONE(bcd),
    .BLANK_CHECK_ERASED(bce), .MEM_READ(mrd), .MEM_WRITE(mwr), .MEM_UNSECURED_SRC(munsec),
    .MEM_RDATA(mdata), .MEM_WRITE_EN(mwen), .MEM_RDATA_OUT(mout),
    .REDIRECT_ENABLE(redir), .SECURE(secure)
  );
  ncdo_nvm_model ncdo_nvm_model_inst (
    .clk(clock), .image(image), .mem_read(mrd), .opt(opt), .key(key), .rdata(mdata)
  );
  always #10 clock = ~clock;
  task automatic finish_test;
    $display("counts: checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic hang;
    fails++;
    finish_test;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // hold the request until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] ad, input logic [7:0] d);
    int k;
    k = 0;
    addr <= ad;
    wr <= w;
    rd <= !w;
    wdata <= {24'h0, d};
    do
    begin
      @(posedge clock);
      k++;
    end
    while (waitreq !== 1'b0 && k < 50);
    if (waitreq !== 1'b0)
      hang;
    q = rdata;
    s = resp;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic do_reset;
    resetn <= 1'b0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    repeat (2) @(posedge clock);
  endtask
  task automatic gap;
    g = 0;
    do
    begin
      @(posedge clock);
      g++;
    end
    while (tick !== 1'b1 && g < 600);
    if (g >= 600)
      hang;
  endtask
  task automatic op_try;
    opreq <= 1'b1;
    @(posedge clock);
    opreq <= 1'b0;
    @(posedge clock);
    a = acc;
    r = refd;
  endtask
  // debug copies first, then the firmware copy
  task automatic key_seq;
    bus(1'b1, `NCDO_ADDR_KCTL, 8'h01);
    for (int i = 0; i < 16; i++)
    begin
      dbg <= (i < 8);
      bus(1'b1, `NCDO_ADDR_KDAT, key[8*(i%8)+:8]);
    end
    dbg <= 1'b0;
    bus(1'b1, `NCDO_ADDR_KCTL, 8'h00);
  endtask
  initial
  begin
    do_reset;
    foreach (rows[i])
    begin
      bus(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w)
        chk(q, rows[i].e);
      chk({30'h0, s}, {30'h0, rows[i].r});
    end
    $display("test register rows done");
    gap;
    gap;
    chk(g, 256);
    op_try;
    chk(a, 1'b1);
    n = (tick === 1'b1);
    for (int c = 0; c < 1000 && done !== 1'b1; c++)
    begin
      opreq <= (c == 0);
      @(posedge clock);
      if (c == 1)
        chk(refd, 1'b1);
      n += (tick === 1'b1 && busy === 1'b1);
    end
    if (done !== 1'b1)
      hang;
    chk(n, 3);
    $display("test operation done");
    for (int i = 0; i < 4; i++)
    begin
      munsec <= i[0];
      mrd <= !i[1];
      mwr <= i[1];
      repeat (2) @(posedge clock);
      if (i[1])
        chk(mwen, !i[0]);
      else
        chk(mout, i[0] ? 8'h00 : 8'h5a);
    end
    mrd <= 1'b0;
    mwr <= 1'b0;
    key_seq;
    repeat (3) @(posedge clock);
    chk(secure, 1'b0);
    bus(1'b0, `NCDO_ADDR_STAT, 8'h00);
    chk(q, 32'h04);
    $display("test security done");
    image <= 1'b1;
    do_reset;
    bus(1'b0, `NCDO_ADDR_OPT, 8'h00);
    chk(q, 32'h03);
    bus(1'b0, `NCDO_ADDR_STAT, 8'h00);
    chk(q, 32'h03);
    op_try;
    chk(r, 1'b1);
    key_seq;
    repeat (3) @(posedge clock);
    chk(secure, 1'b1);
    bcd <= 1'b1;
    bce <= 1'b1;
    @(posedge clock);
    bcd <= 1'b0;
    bce <= 1'b0;
    repeat (2) @(posedge clock);
    chk(secure, 1'b0);
    be <= 4'h0;
    bus(1'b1, `NCDO_ADDR_DIV, 8'h40);
    be <= 4'h1;
    bus(1'b1, `NCDO_ADDR_DIV, 8'h00);
    bus(1'b0, `NCDO_ADDR_DIV, 8'h00);
    chk(q, 32'h80);
    gap;
    gap;
    chk(g, 1);
    $display("test second reset done");
    finish_test;
  end
endmodule
